// ---- logic/tmc_consts.svh ----
// offsets, field positions, reset values and timing constants of the timer core
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// per-timer register offsets inside an 8-byte slot
`define TMC_OFF_C0      3'h0
`define TMC_OFF_C1      3'h1
`define TMC_OFF_DL      3'h2
`define TMC_OFF_DH      3'h3
`define TMC_OFF_AL      3'h4
`define TMC_OFF_AH      3'h5
`define TMC_OFF_PL      3'h6
`define TMC_OFF_PH      3'h7
// shared interrupt registers
`define TMC_OFF_IST     6'h20
`define TMC_OFF_IMSK    6'h21

// first control register fields
`define TMC_C0_PAUSE    7
`define TMC_C0_CKS_HI   6
`define TMC_C0_CKS_LO   4
`define TMC_C0_ON       3
`define TMC_C0_CSRC     0
`define TMC_C0_WMASK    8'hF9
// second control register fields
`define TMC_C1_MODE_HI  7
`define TMC_C1_MODE_LO  6
`define TMC_C1_IO_HI    5
`define TMC_C1_IO_LO    4
`define TMC_C1_OC       3
`define TMC_C1_POL      2
`define TMC_C1_DPX      1
`define TMC_C1_CCLR     0

`define TMC_RST_BYTE    8'h00
`define TMC_RST_WORD    16'h0000

// timing
`define TMC_FSYS_HZ     100000000
`define TMC_FSUB_HZ     32768

`endif

// ---- logic/tmc_pkg.sv ----
// types shared by the timer core and its environment
`default_nettype none
package tmc_pkg;

   typedef enum logic [1:0] {
      TMC_MODE_CMP = 2'b00,
      TMC_MODE_CAP = 2'b01,
      TMC_MODE_PWM = 2'b10,
      TMC_MODE_TMR = 2'b11
   } tmc_mode_e;

   typedef enum logic [2:0] {
      TMC_CKS_SYS4  = 3'b000,
      TMC_CKS_SYS   = 3'b001,
      TMC_CKS_H16   = 3'b010,
      TMC_CKS_H64   = 3'b011,
      TMC_CKS_SUBA  = 3'b100,
      TMC_CKS_SUBB  = 3'b101,
      TMC_CKS_EXTR  = 3'b110,
      TMC_CKS_EXTF  = 3'b111
   } tmc_cks_e;

   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmc_bus_s;

   typedef struct packed {
      logic [7:0]  c0;
      logic [7:0]  c1;
      logic [7:0]  lbuf;
      logic [15:0] cnt;
      logic [15:0] cca;
      logic [15:0] ccp;
      logic        out;
      logic        pulse;
      logic        on_q;
      logic        pin;
   } tmc_tm_s;

   typedef struct packed {
      tmc_tm_s [3:0] tm;
      logic [7:0]    ist;
      logic [7:0]    imask;
      logic [7:0]    rdata;
      logic [5:0]    pre;
      logic [11:0]   sub;
      logic [3:0]    ck1;
      logic [3:0]    ck2;
      logic [3:0]    ck3;
      logic [3:0]    cp1;
      logic [3:0]    cp2;
      logic [3:0]    cp3;
   } tmc_state_s;

endpackage : tmc_pkg
`default_nettype wire

// ---- logic/tmc_top.sv ----
// four-timer core: one standard timer and three periodic timers behind a byte bus
// Operation
// - four timers: one 16-bit standard, three 10-bit periodic counters
// - free-running counter matches comparators, interrupts, may clear and set pin
// - two interrupt sources per timer: comparator A and comparator P
// - clock select chooses system divisions, high clock, sub clock or pin
// - external clock pin counts on rising or falling edge as selected
// - single pulse mode starts its pulse from the external clock pin
// - capture pin edge: rising, falling or both, set by pin function field
// - periodic timers may capture from their external clock pin instead
// - each timer drives one pin; standard and first periodic add inverted pin
// - compare mode drives pins high, low or toggles on match
// - pwm waveform appears on the same output pins
// - edge-aligned pwm only; software adjusts either duty or period
// - high byte direct, low byte through 8-bit buffer on high access
// - low byte write fills buffer; high write loads both bytes
// - high byte read latches low byte into buffer for later low read
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "tmc_consts.svh"

module tmc_top #(
   parameter int STD_WIDTH = 16,
   parameter int PER_WIDTH = 10
) (
   input  wire logic             CLOCK,
   input  wire logic             RSTN,
   input  wire tmc_pkg::tmc_bus_s BUS,
   output logic [7:0]            RDATA,
   input  wire logic [3:0]       EXT_CLK,
   input  wire logic [3:0]       CAP_IN,
   output logic [3:0]            TOUT,
   output logic [3:0]            TOUT_N,
   output logic                  IRQ
);
   import tmc_pkg::*;

   localparam int SUB_DIV = `TMC_FSYS_HZ / `TMC_FSUB_HZ;

   // refuse widths that the byte pairs and the 16-bit state fields cannot carry
   if (STD_WIDTH < 9 || STD_WIDTH > 16 || PER_WIDTH < 9 || PER_WIDTH > 16) begin : g_width_chk
      $error("tmc_top: counter widths must lie between 9 and 16");
   end

   // counter width of each timer, as a value mask
   function automatic logic [15:0] tmc_wmask(input int n);
      int w;
      w = (n == 0) ? STD_WIDTH : PER_WIDTH;
      tmc_wmask = 16'hFFFF >> (16 - w);
   endfunction : tmc_wmask

   // one-cycle count enable for a clock-select code
   function automatic logic tmc_tick(input logic [2:0] cks, input logic [5:0] pre,
                                     input logic subt, input logic rise, input logic fall);
      case (tmc_cks_e'(cks))
         TMC_CKS_SYS4: tmc_tick = (pre[1:0] == 2'h3);
         TMC_CKS_SYS:  tmc_tick = 1'b1;
         TMC_CKS_H16:  tmc_tick = (pre[3:0] == 4'hF);
         TMC_CKS_H64:  tmc_tick = (pre == 6'h3F);
         TMC_CKS_SUBA: tmc_tick = subt;
         TMC_CKS_SUBB: tmc_tick = subt;
         TMC_CKS_EXTR: tmc_tick = rise;
         TMC_CKS_EXTF: tmc_tick = fall;
         default:      tmc_tick = 1'b0;
      endcase
   endfunction : tmc_tick

   tmc_state_s s_q;
   tmc_state_s s_d;

   always_comb begin
      tmc_tm_s     t;
      logic [15:0] wm;
      logic [15:0] duty;
      logic [7:0]  ev;
      logic [7:0]  rd_v;
      logic [7:0]  w1c;
      logic [1:0]  mode;
      logic [1:0]  io;
      logic        subt;
      logic        ck_r;
      logic        ck_f;
      logic        cp_r;
      logic        cp_f;
      logic        cap_r;
      logic        cap_f;
      logic        cap;
      logic        tick;
      logic        run;
      logic        ma;
      logic        mp;
      logic        clr;
      logic        lvl;
      logic        sp;
      logic [1:0]  sel;
      logic [2:0]  off;
      s_d  = s_q;
      ev   = 8'h00;
      rd_v = 8'h00;
      w1c  = 8'h00;
      t    = s_q.tm[0];
      wm   = 16'h0000;
      duty = 16'h0000;
      mode = 2'b00;
      io   = 2'b00;
      ck_r = 1'b0;
      ck_f = 1'b0;
      cp_r = 1'b0;
      cp_f = 1'b0;
      cap_r = 1'b0;
      cap_f = 1'b0;
      cap  = 1'b0;
      tick = 1'b0;
      run  = 1'b0;
      ma   = 1'b0;
      mp   = 1'b0;
      clr  = 1'b0;
      lvl  = 1'b0;
      sp   = 1'b0;
      subt = 1'b0;
      sel  = BUS.addr[4:3];
      off  = BUS.addr[2:0];

      s_d.pre = s_q.pre + 6'h01;
      subt    = (s_q.sub == 12'(SUB_DIV - 1));
      s_d.sub = subt ? 12'h000 : s_q.sub + 12'h001;

      // pins cross into the clock domain through two flops
      s_d.ck1 = EXT_CLK;
      s_d.ck2 = s_q.ck1;
      s_d.ck3 = s_q.ck2;
      s_d.cp1 = CAP_IN;
      s_d.cp2 = s_q.cp1;
      s_d.cp3 = s_q.cp2;

      for (int n = 0; n < 4; n++) begin
         t    = s_q.tm[n];
         wm   = tmc_wmask(n);
         mode = t.c1[`TMC_C1_MODE_HI:`TMC_C1_MODE_LO];
         io   = t.c1[`TMC_C1_IO_HI:`TMC_C1_IO_LO];
         // edge of the external clock pin
         ck_r = s_q.ck2[n] & ~s_q.ck3[n];
         ck_f = ~s_q.ck2[n] & s_q.ck3[n];
         cp_r = s_q.cp2[n] & ~s_q.cp3[n];
         cp_f = ~s_q.cp2[n] & s_q.cp3[n];
         tick = tmc_tick(t.c0[`TMC_C0_CKS_HI:`TMC_C0_CKS_LO], s_q.pre, subt, ck_r, ck_f);
         sp   = (tmc_mode_e'(mode) == TMC_MODE_PWM) && (io == 2'b11);
         // single pulse mode only counts while its pulse is live
         run  = t.c0[`TMC_C0_ON] & ~t.c0[`TMC_C0_PAUSE] & (~sp | t.pulse);
         ma   = (t.cnt == t.cca);
         mp   = (t.cnt == t.ccp);
         // periodic timers may take the clock pin as capture source
         cap_r = (n != 0 && t.c0[`TMC_C0_CSRC]) ? ck_r : cp_r;
         cap_f = (n != 0 && t.c0[`TMC_C0_CSRC]) ? ck_f : cp_f;
         case (io)
            2'b00:   cap = cap_r;
            2'b01:   cap = cap_f;
            2'b10:   cap = cap_r | cap_f;
            default: cap = 1'b0;
         endcase
         t.on_q = t.c0[`TMC_C0_ON];
         if (t.c0[`TMC_C0_ON] && !s_q.tm[n].on_q) begin
            // switching on restarts the count and the pin's initial level
            t.cnt   = `TMC_RST_WORD;
            t.out   = t.c1[`TMC_C1_OC];
            t.pulse = 1'b0;
         end else begin
            if (run && tick) begin
               // pwm period comes from P or A as selected
               if (tmc_mode_e'(mode) == TMC_MODE_PWM) begin
                  clr = t.c1[`TMC_C1_DPX] ? ma : mp;
               end else begin
                  clr = t.c1[`TMC_C1_CCLR] ? ma : mp;
               end
               // match clears or advances the counter
               t.cnt = clr ? `TMC_RST_WORD : (t.cnt + 16'h0001) & wm;
               ev[2 * n]     = ma & (tmc_mode_e'(mode) != TMC_MODE_CAP);
               ev[2 * n + 1] = mp;
               if (tmc_mode_e'(mode) == TMC_MODE_CMP && ma) begin
                  case (io)
                     2'b01:   t.out = 1'b0;
                     2'b10:   t.out = 1'b1;
                     2'b11:   t.out = ~t.out;
                     default: t.out = t.out;
                  endcase
               end
               if (sp && ma) begin
                  t.pulse = 1'b0;
               end
            end
            // external trigger starts a single pulse
            if (sp && t.c0[`TMC_C0_ON] && !t.pulse && ck_r) begin
               t.pulse = 1'b1;
               t.cnt   = `TMC_RST_WORD;
            end
            if (tmc_mode_e'(mode) == TMC_MODE_CAP && t.c0[`TMC_C0_ON] && cap) begin
               t.cca  = t.cnt;
               ev[2 * n] = 1'b1;
            end
         end
         // edge-aligned duty: active from counter zero until duty value
         duty = t.c1[`TMC_C1_DPX] ? t.ccp : t.cca;
         if (tmc_mode_e'(mode) == TMC_MODE_PWM) begin
            // pwm uses the compare output pins
            case (io)
               2'b00:   lvl = ~t.c1[`TMC_C1_OC];
               2'b01:   lvl = t.c1[`TMC_C1_OC];
               2'b10:   lvl = (t.cnt < duty) ? t.c1[`TMC_C1_OC] : ~t.c1[`TMC_C1_OC];
               default: lvl = t.pulse ? t.c1[`TMC_C1_OC] : ~t.c1[`TMC_C1_OC];
            endcase
         end else begin
            lvl = t.out;
         end
         t.pin = lvl ^ t.c1[`TMC_C1_POL];
         s_d.tm[n] = t;
      end

      // register bus; timer register writes win over same-cycle timer updates
      if (!BUS.addr[5]) begin
         t  = s_d.tm[sel];
         wm = tmc_wmask(int'(sel));
         if (BUS.wr) begin
            case (off)
               `TMC_OFF_C0: t.c0 = BUS.wdata & `TMC_C0_WMASK;
               `TMC_OFF_C1: t.c1 = BUS.wdata;
               // low write goes to the buffer only
               `TMC_OFF_AL: t.lbuf = BUS.wdata;
               `TMC_OFF_PL: t.lbuf = BUS.wdata;
               // high write loads both bytes at once
               `TMC_OFF_AH: t.cca = {BUS.wdata, t.lbuf} & wm;
               `TMC_OFF_PH: t.ccp = {BUS.wdata, t.lbuf} & wm;
               default:     t.lbuf = t.lbuf;
            endcase
         end
         if (BUS.rd) begin
            case (off)
               `TMC_OFF_C0: rd_v = s_q.tm[sel].c0;
               `TMC_OFF_C1: rd_v = s_q.tm[sel].c1;
               // high read latches the low byte
               `TMC_OFF_DH: begin
                  rd_v   = s_q.tm[sel].cnt[15:8] & wm[15:8];
                  t.lbuf = s_q.tm[sel].cnt[7:0];
               end
               `TMC_OFF_AH: begin
                  rd_v   = s_q.tm[sel].cca[15:8] & wm[15:8];
                  t.lbuf = s_q.tm[sel].cca[7:0];
               end
               `TMC_OFF_PH: begin
                  rd_v   = s_q.tm[sel].ccp[15:8] & wm[15:8];
                  t.lbuf = s_q.tm[sel].ccp[7:0];
               end
               // low bytes come from the buffer
               default: rd_v = s_q.tm[sel].lbuf;
            endcase
         end
         s_d.tm[sel] = t;
      end else begin
         if (BUS.wr && BUS.addr == `TMC_OFF_IST) begin
            w1c = BUS.wdata;
         end
         if (BUS.wr && BUS.addr == `TMC_OFF_IMSK) begin
            s_d.imask = BUS.wdata;
         end
         if (BUS.rd && BUS.addr == `TMC_OFF_IST) begin
            rd_v = s_q.ist;
         end
         if (BUS.rd && BUS.addr == `TMC_OFF_IMSK) begin
            rd_v = s_q.imask;
         end
      end

      // sticky events: a set in the clearing cycle survives
      s_d.ist   = (s_q.ist & ~w1c) | ev;
      s_d.rdata = BUS.rd ? rd_v : `TMC_RST_BYTE;
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // inverted pins exist on the standard and first periodic timers only
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         TOUT[n] = s_q.tm[n].pin;
      end
      TOUT_N = {2'b00, ~s_q.tm[1].pin, ~s_q.tm[0].pin};
   end

   assign RDATA = s_q.rdata;
   assign IRQ   = |(s_q.ist & s_q.imask);

endmodule : tmc_top
`default_nettype wire

// ---- tb/tmc_pins_model.sv ----
// pin-side model: clean pulses on the clock/trigger and capture pins
`timescale 1ns/10ps
`default_nettype none
module tmc_pins_model (
   input  wire logic  clk,
   output logic [3:0] ext_pin,
   output logic [3:0] cap_pin
);
   initial begin
      ext_pin = 4'h0;
      cap_pin = 4'h0;
   end
   // three clocks per level, above the two-clock minimum of the synchroniser
   task automatic pulse(input logic cap, input int idx);
      @(posedge clk);
      if (cap) cap_pin[idx] <= 1'b1;
      else ext_pin[idx] <= 1'b1;
      repeat (3) @(posedge clk);
      if (cap) cap_pin[idx] <= 1'b0;
      else ext_pin[idx] <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulse
endmodule : tmc_pins_model
`default_nettype wire

// ---- tb/tmc_top_props.sv ----
// port-level assertions for the timer core
`timescale 1ns/10ps
`default_nettype none
module tmc_top_props (
   input wire logic              CLOCK,
   input wire logic              RSTN,
   input wire tmc_pkg::tmc_bus_s BUS,
   input wire logic [7:0]        RDATA,
   input wire logic [3:0]        TOUT,
   input wire logic [3:0]        TOUT_N,
   input wire logic              IRQ
);
   import tmc_pkg::*;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   logic per_hi;
   // read of a high byte of a periodic timer pair
   assign per_hi = BUS.rd && !BUS.addr[5] && BUS.addr[4:3] != 2'h0 && BUS.addr[0]
                   && BUS.addr[2:1] != 2'h0;
   property p_rd_idle; !BUS.rd |=> RDATA == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_unmapped; BUS.rd && BUS.addr > 6'h21 |=> RDATA == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_per_hi; per_hi |=> RDATA[7:2] == 6'h00; endproperty
   a_per_hi: assert property (p_per_hi) else $error("unused high bits set");
   property p_hi_wr;
      BUS.wr && BUS.addr == 6'h05 ##1 BUS.rd && BUS.addr == 6'h05 |=> RDATA == $past(BUS.wdata, 2);
   endproperty
   a_hi_wr: assert property (p_hi_wr) else $error("high byte write lost");
   property p_lo_rd;
      BUS.wr && BUS.addr == 6'h04 ##1 BUS.wr && BUS.addr == 6'h05 ##1 BUS.rd && BUS.addr == 6'h05
      ##1 BUS.rd && BUS.addr == 6'h04 |=> RDATA == $past(BUS.wdata, 4);
   endproperty
   a_lo_rd: assert property (p_lo_rd) else $error("low byte not via buffer");
   property p_inv_pin; TOUT_N[1:0] == ~TOUT[1:0]; endproperty
   a_inv_pin: assert property (p_inv_pin) else $error("inverted pin mismatch");
   property p_inv_tied; TOUT_N[3:2] == 2'h0; endproperty
   a_inv_tied: assert property (p_inv_tied) else $error("absent inverted pin driven");
   property p_irq_fall;
      $fell(IRQ) |-> $past(BUS.wr) && ($past(BUS.addr) == 6'h20 || $past(BUS.addr) == 6'h21);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped unasked");
endmodule : tmc_top_props
`default_nettype wire

// ---- tb/tmc_top_bench.sv ----
// self-checking bench for the four-timer core
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tmc_top_bench;
   import tmc_pkg::*;
   localparam logic [1:0] KW = 2'h2, KR = 2'h1, KI = 2'h0;
   logic       clock = 1'b0;
   logic       rstn = 1'b0;
   tmc_bus_s   bus = '0;
   logic [7:0] rdata, v;
   logic [3:0] ext_clk, cap_in, tout, tout_n;
   logic       irq;
   int         failures = 0;
   int         num_checks = 0;
   int         n;
   // rows: low address, low, high, high read back
   logic [5:0] ra [4] = '{6'h04, 6'h0C, 6'h16, 6'h1C};
   logic [7:0] rl [4] = '{8'h34, 8'hAB, 8'h55, 8'h00};
   logic [7:0] rh [4] = '{8'h12, 8'hFF, 8'h02, 8'hFE};
   logic [7:0] re [4] = '{8'h12, 8'h03, 8'h02, 8'h02};
   logic [7:0] cm [4] = '{8'h19, 8'h21, 8'h31, 8'h09};
   logic       co [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
   logic [7:0] c1 [5] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h40};
   logic [7:0] c0 [5] = '{8'h18, 8'h18, 8'h18, 8'h18, 8'h19};
   logic       cs [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
   logic       ce [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
   logic [7:0] ev [2] = '{8'h68, 8'h78};
   // rows: control word with clock select, cycles waited, count expected
   logic [7:0] dc [4] = '{8'h08, 8'h28, 8'h38, 8'h98};
   int         dw [4] = '{40, 64, 128, 40};
   logic [7:0] dn [4] = '{8'h0A, 8'h04, 8'h02, 8'h00};
   // rows: pwm control word, high cycles out of sixty
   logic [7:0] pc [4] = '{8'hA8, 8'hAC, 8'h88, 8'h98};
   int         ph [4] = '{20, 40, 0, 60};
   int         hi3 = 0;

   tmc_top dut (.CLOCK(clock), .RSTN(rstn), .BUS(bus), .RDATA(rdata), .EXT_CLK(ext_clk),
      .CAP_IN(cap_in), .TOUT(tout), .TOUT_N(tout_n), .IRQ(irq));
   tmc_pins_model pins (.clk(clock), .ext_pin(ext_clk), .cap_pin(cap_in));

   always #5 clock = ~clock;

   // running count of cycles with the last timer's pin high
   always @(posedge clock) hi3 <= hi3 + ((tout[3] === 1'b1) ? 1 : 0);

   // v holds the answer to the request before this one
   task automatic op(input logic [1:0] k, input logic [5:0] a, input logic [7:0] d);
      bus <= {a, d, k};
      @(posedge clock);
      v = rdata;
   endtask : op

   task automatic rd(input logic [5:0] a);
      op(KR, a, 8'h00);
      op(KI, 6'h00, 8'h00);
   endtask : rd

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (5000) @(posedge clock);
      failures++;
      tally_and_finish();
   end

   initial begin
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      `CHK(tout, 4'h0)
      `CHK(tout_n, 4'h3)
      `CHK(irq, 1'b0)
      // low then high on write, high then low on read
      for (int i = 0; i < 4; i++) begin
         op(KW, ra[i], rl[i]);
         op(KW, ra[i] + 6'h01, rh[i]);
         op(KR, ra[i] + 6'h01, 8'h00);
         op(KR, ra[i], 8'h00);
         `CHK(v, re[i])
         op(KI, 6'h00, 8'h00);
         `CHK(v, rl[i])
      end
      // a lone low write stays in the buffer
      op(KW, 6'h04, 8'h99);
      op(KR, 6'h05, 8'h00);
      op(KR, 6'h04, 8'h00);
      `CHK(v, 8'h12)
      op(KI, 6'h00, 8'h00);
      `CHK(v, 8'h34)
      op(KW, 6'h04, 8'h03);
      op(KW, 6'h05, 8'h00);
      op(KW, 6'h21, 8'h01);
      // every pin action on an A match
      for (int i = 0; i < 4; i++) begin
         op(KW, 6'h00, 8'h10);
         op(KW, 6'h20, 8'hFF);
         op(KW, 6'h01, cm[i]);
         op(KW, 6'h00, 8'h18);
         op(KI, 6'h00, 8'h00);
         n = 0;
         while (irq !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
         end
         @(posedge clock);
         `CHK(irq, 1'b1)
         `CHK(tout[0], co[i])
      end
      rd(6'h20);
      `CHK(v[0], 1'b1)
      op(KW, 6'h21, 8'h00);
      op(KI, 6'h00, 8'h00);
      `CHK(irq, 1'b0)
      op(KW, 6'h21, 8'h01);
      op(KI, 6'h00, 8'h00);
      `CHK(irq, 1'b1)
      op(KW, 6'h00, 8'h10);
      op(KW, 6'h20, 8'hFF);
      op(KI, 6'h00, 8'h00);
      `CHK(irq, 1'b0)
      op(KW, 6'h0E, 8'hFF);
      op(KW, 6'h0F, 8'h03);
      op(KW, 6'h09, 8'hC0);
      for (int i = 0; i < 2; i++) begin
         op(KW, 6'h08, 8'h00);
         op(KW, 6'h08, ev[i]);
         op(KI, 6'h00, 8'h00);
         repeat (5) pins.pulse(1'b0, 1);
         repeat (4) @(posedge clock);
         op(KR, 6'h0B, 8'h00);
         op(KR, 6'h0A, 8'h00);
         `CHK(v, 8'h00)
         op(KI, 6'h00, 8'h00);
         `CHK(v, 8'h05)
      end
      // capture edges, disable and alternate source
      for (int i = 0; i < 5; i++) begin
         op(KW, 6'h10, 8'h10);
         op(KW, 6'h20, 8'hFF);
         op(KW, 6'h11, c1[i]);
         op(KW, 6'h10, c0[i]);
         op(KI, 6'h00, 8'h00);
         pins.pulse(cs[i], 2);
         repeat (4) @(posedge clock);
         rd(6'h20);
         `CHK(v[4], ce[i])
      end
      // divided system clocks and pause on the last periodic timer
      op(KW, 6'h1E, 8'hFF);
      op(KW, 6'h1F, 8'h03);
      op(KW, 6'h19, 8'hC0);
      for (int i = 0; i < 4; i++) begin
         op(KW, 6'h18, 8'h00);
         op(KW, 6'h18, dc[i]);
         op(KI, 6'h00, 8'h00);
         repeat (dw[i]) @(posedge clock);
         op(KR, 6'h1B, 8'h00);
         op(KR, 6'h1A, 8'h00);
         `CHK(v, 8'h00)
         op(KI, 6'h00, 8'h00);
         `CHK(v, dn[i])
      end
      // edge-aligned pwm: period P = 5, duty A = 2
      op(KW, 6'h1C, 8'h02);
      op(KW, 6'h1D, 8'h00);
      op(KW, 6'h1E, 8'h05);
      op(KW, 6'h1F, 8'h00);
      for (int i = 0; i < 4; i++) begin
         op(KW, 6'h18, 8'h10);
         op(KW, 6'h19, pc[i]);
         op(KW, 6'h18, 8'h18);
         op(KI, 6'h00, 8'h00);
         // skip the cycle whose pin level still comes from the stopped counter
         @(posedge clock);
         n = hi3;
         repeat (60) @(posedge clock);
         `CHK(hi3 - n, ph[i])
      end
      // single pulse started by a rising trigger, A + 1 cycles long
      op(KW, 6'h18, 8'h10);
      op(KW, 6'h19, 8'hB8);
      op(KW, 6'h18, 8'h18);
      op(KI, 6'h00, 8'h00);
      @(posedge clock);
      `CHK(tout[3], 1'b0)
      n = hi3;
      pins.pulse(1'b0, 3);
      repeat (4) @(posedge clock);
      `CHK(hi3 - n, 3)
      `CHK(tout[3], 1'b0)
      op(KW, 6'h22, 8'hFF);
      rd(6'h22);
      `CHK(v, 8'h00)
      rd(6'h3F);
      `CHK(v, 8'h00)
      tally_and_finish();
   end
endmodule : tmc_top_bench

bind tmc_top tmc_top_props chk (.CLOCK(CLOCK), .RSTN(RSTN), .BUS(BUS), .RDATA(RDATA),
   .TOUT(TOUT), .TOUT_N(TOUT_N), .IRQ(IRQ));
`default_nettype wire
